/* File: verilog/sdt_pkg.sv */
// constants shared by the split dual byte timer and its helpers
// assumes a single clock domain and an apb master outside
package sdt_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CLK_SELECT  = 6'h00;
  localparam logic [5:0] IDX_BYTE_MODE   = 6'h04;
  localparam logic [5:0] IDX_UNF_LVL     = 6'h06;
  localparam logic [5:0] IDX_CMP_LVL     = 6'h07;
  localparam logic [5:0] IDX_CMD         = 6'h08;
  localparam logic [5:0] IDX_FLAGS       = 6'h0C;
  localparam logic [5:0] IDX_LOW_COUNT   = 6'h20;
  localparam logic [5:0] IDX_HIGH_COUNT  = 6'h21;
  localparam logic [5:0] IDX_HIGH_PERIOD = 6'h26;
  localparam logic [5:0] IDX_LOW_PERIOD  = 6'h27;
  localparam logic [5:0] IDX_CMP_BASE    = 6'h28;
  localparam int         N_CMP           = 4;
  localparam int         N_IRQ           = 6;
  localparam int         PRE_W           = 10;
  localparam int         CMD_LSB         = 2;
  localparam int         FLAG_LOW_UNF    = 0;
  localparam int         FLAG_HIGH_UNF   = 1;
  localparam int         FLAG_CMP_LSB    = 4;
  localparam logic [7:0] MODE_MASK       = 8'h03;
  localparam logic [7:0] UNF_LVL_MASK    = 8'h0F;
  localparam logic [7:0] CLK_MASK        = 8'h0F;
  localparam logic [7:0] FLAG_MASK       = 8'hF3;
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam logic [7:0] CNT_BOTTOM      = 8'h00;
  localparam logic [3:0] CLK_OFF         = 4'h0;
  localparam int         CLK_EVENT_BIT   = 3;
  // prescaler masks per clock select code 1..7 (1,2,4,8,64,256,1024)
  localparam logic [PRE_W-1:0] PRE_MASK [8] = '{
    10'h000, 10'h000, 10'h001, 10'h003, 10'h007, 10'h03F, 10'h0FF, 10'h3FF};
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00, MODE_UPPER_CLEAR = 2'b01,
    MODE_TWO_COUNTER = 2'b10, MODE_RESERVED = 2'b11
  } sdt_mode_t;
  typedef enum logic [1:0] {
    CMD_NONE = 2'b00, CMD_RESERVED = 2'b01,
    CMD_RESTART = 2'b10, CMD_HARD_RESET = 2'b11
  } sdt_cmd_t;
endpackage : sdt_pkg

/* File: verilog/sdt_if.sv */
// bundles between the timer top and its register port and counter halves
// assumes all ends run on clk_sys
`timescale 1ns/100ps
`default_nettype none
interface sdt_half_if;
  logic       tick;    // count step this cycle
  logic       clear;   // restart, hard reset or upper clear
  logic       wr;      // cpu write of the count
  logic [7:0] wdata;   // cpu write value
  logic [7:0] period;  // reload value
  logic [7:0] count;   // current count
  logic       bottom;  // tick taken while at bottom
  modport ctl (output tick, clear, wr, wdata, period, input count, bottom);
  modport cnt (input tick, clear, wr, wdata, period, output count, bottom);
endinterface : sdt_half_if

interface sdt_reg_if;
  logic       wr;     // one-cycle write strobe
  logic [5:0] idx;    // register index
  logic [7:0] wdata;  // write byte
  logic [7:0] rdata;  // read byte for idx
  logic       hit;    // idx is mapped
  modport bus (output wr, idx, wdata, input rdata, hit);
  modport regs (input wr, idx, wdata, output rdata, hit);
endinterface : sdt_reg_if
`default_nettype wire

/* File: verilog/sdt_apb_port.sv */
// apb slave turning transfers into register strobes
// assumes an apb master on clk_sys; read data is taken in the setup cycle
`timescale 1ns/100ps
`default_nettype none
module sdt_apb_port
  import sdt_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  sdt_reg_if.bus           rif
);
  logic taken;   // read data captured for this transfer
  logic miss;    // captured address was unmapped
  wire  cap     = psel & ~taken & ce;
  wire  mapped  = rif.hit & (paddr[1:0] == 2'b00);
  wire  done    = psel & penable & taken & ce;

  assign rif.idx   = paddr[7:2];
  assign rif.wdata = pwdata[7:0];
  // write lands on the completing edge only
  assign rif.wr    = done & pwrite & ~miss;
  assign pready    = penable & taken & ce;
  assign pslverr   = pready & miss;

  // capture read byte and decode once, hold until completion
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      taken  <= 1'b0;
      miss   <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (cap) begin
      taken  <= 1'b1;
      miss   <= ~mapped;
      prdata <= mapped ? {24'h00_0000, rif.rdata} : 32'h0000_0000;
    end else if (done) begin
      taken  <= 1'b0;
    end
  end
endmodule : sdt_apb_port
`default_nettype wire

/* File: verilog/sdt_half_counter.sv */
// one eight-bit down counter half with reload
// assumes ticks, clears and writes come from the same clock
`timescale 1ns/100ps
`default_nettype none
module sdt_half_counter
  import sdt_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic ce,
  sdt_half_if.cnt   hif
);
  logic [7:0] count;       // counter state
  logic [7:0] next_count;  // value for next edge
  wire        at_bottom = (count == CNT_BOTTOM);

  assign hif.bottom = hif.tick & at_bottom;
  assign next_count = hif.wr    ? hif.wdata :
                      hif.clear ? CNT_BOTTOM :
                      hif.tick  ? (at_bottom ? hif.period : count - 8'h01) :
                      count;
  assign hif.count  = count;

  // frozen while ce is low
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) count <= REG_RESET;
    else if (ce) count <= next_count;
  end
endmodule : sdt_half_counter
`default_nettype wire

/* File: verilog/sdt_timer.sv */
// split dual byte timer: registers, clocking, modes, commands, flags
// assumes apb master on clk_sys and event inputs already on clk_sys
`timescale 1ns/100ps
`default_nettype none
module sdt_timer
  import sdt_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  event_in,
  input  wire logic [5:0]  irq_ack,
  output var  logic [11:0] irq_level,
  output var  logic [3:0]  wave_out
);
  // bundles to the register port and both halves
  sdt_reg_if  rif ();
  sdt_half_if lo ();
  sdt_half_if hi ();

  // software visible state, shared by both halves
  logic [3:0]  clk_select;               // 0 stops both halves
  sdt_mode_t   operation_mode_select;    // counting mode

  // request levels; each half owns its pair so a hard reset stays local
  logic [1:0]  low_underflow_irq_level;  // low half underflow level
  logic [1:0]  high_underflow_irq_level; // high half underflow level
  wire  [3:0]  underflow_irq_level = {high_underflow_irq_level, low_underflow_irq_level};
  logic [7:0]  compare_irq_level;        // two bits per channel

  // flags and reload values
  logic [7:0]  irq_flags;                // bits 3:2 always zero
  logic [7:0]  low_period;               // low half top value
  logic [7:0]  high_period;              // high half top value

  // compare values of the low half, one per channel
  logic [7:0]  low_compare_value [N_CMP];

  // clocking state
  logic [PRE_W-1:0] pre_cnt;        // free prescaler
  logic [PRE_W-1:0] pre_mask;       // selected division mask
  logic             tick;           // timer clock for this cycle

  // register port
  sdt_apb_port u_apb (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .ce      (ce),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .rif     (rif)
  );

  // low byte counter half
  sdt_half_counter u_low (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .ce      (ce),
    .hif     (lo)
  );

  // high byte counter half
  sdt_half_counter u_high (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .ce      (ce),
    .hif     (hi)
  );

  // write strobes per register
  wire wr_clk   = rif.wr & (rif.idx == IDX_CLK_SELECT);
  wire wr_mode  = rif.wr & (rif.idx == IDX_BYTE_MODE);
  wire wr_unf   = rif.wr & (rif.idx == IDX_UNF_LVL);
  wire wr_cmpl  = rif.wr & (rif.idx == IDX_CMP_LVL);
  wire wr_cmd   = rif.wr & (rif.idx == IDX_CMD);
  wire wr_flags = rif.wr & (rif.idx == IDX_FLAGS);
  wire wr_low_count  = rif.wr & (rif.idx == IDX_LOW_COUNT);
  wire wr_high_count  = rif.wr & (rif.idx == IDX_HIGH_COUNT);
  wire wr_high_period  = rif.wr & (rif.idx == IDX_HIGH_PERIOD);
  wire wr_low_half_period  = rif.wr & (rif.idx == IDX_LOW_PERIOD);

  // compare value slots sit on even indices from the base
  wire [5:0] cmp_off = rif.idx - IDX_CMP_BASE;
  wire       cmp_hit = (rif.idx >= IDX_CMP_BASE) & ~cmp_off[0]
                       & (cmp_off[5:1] < 5'(N_CMP));
  wire [1:0] cmp_sel = cmp_off[2:1];

  // command decode; the command byte itself is never stored
  // acts only on the write strobe
  wire [1:0] cmd_code = rif.wdata[CMD_LSB+1:CMD_LSB];
  // target bit 0 low, bit 1 high
  wire       tgt_lo   = rif.wdata[0];
  wire       tgt_hi   = rif.wdata[1];
  wire       cmd_lo   = wr_cmd & tgt_lo;
  wire       cmd_hi   = wr_cmd & tgt_hi;
  wire       is_restart = (cmd_code == CMD_RESTART);
  wire       is_hard  = (cmd_code == CMD_HARD_RESET) & (clk_select == CLK_OFF);
  wire       rst_lo   = cmd_lo & is_restart;
  wire       rst_hi   = cmd_hi & is_restart;
  wire       hard_lo  = cmd_lo & is_hard;
  wire       hard_hi  = cmd_hi & is_hard;

  // mapped index check for the register port; anything else is refused
  assign rif.hit = (rif.idx == IDX_CLK_SELECT)
                 | (rif.idx == IDX_BYTE_MODE)
                 | (rif.idx == IDX_UNF_LVL)
                 | (rif.idx == IDX_CMP_LVL)
                 | (rif.idx == IDX_CMD)
                 | (rif.idx == IDX_FLAGS)
                 | (rif.idx == IDX_LOW_COUNT)
                 | (rif.idx == IDX_HIGH_COUNT)
                 | (rif.idx == IDX_HIGH_PERIOD)
                 | (rif.idx == IDX_LOW_PERIOD)
                 | cmp_hit;

  // read mux; reserved bits come back zero
  // reserved bits read zero
  assign rif.rdata =
      (rif.idx == IDX_CLK_SELECT)  ? {4'h0, clk_select} :
      (rif.idx == IDX_BYTE_MODE)   ? {6'h00, operation_mode_select} :
      (rif.idx == IDX_UNF_LVL)     ? {4'h0, underflow_irq_level} :
      (rif.idx == IDX_CMP_LVL)     ? compare_irq_level :
      (rif.idx == IDX_FLAGS)       ? irq_flags :
      (rif.idx == IDX_LOW_COUNT)   ? lo.count :
      (rif.idx == IDX_HIGH_COUNT)  ? hi.count :
      (rif.idx == IDX_HIGH_PERIOD) ? high_period :
      (rif.idx == IDX_LOW_PERIOD)  ? low_period :
      cmp_hit                      ? low_compare_value[cmp_sel] :
      // the command register always reads zero
      REG_RESET;

  // timer clock: prescaler tap or an event channel
  // event channels arrive on clk_sys already, so no synchroniser here
  // select 0 gives no tick at all, which is the stopped state
  assign pre_mask = PRE_MASK[clk_select[2:0]];
  assign tick = clk_select[CLK_EVENT_BIT] ? event_in[clk_select[2:0]] :
                (clk_select != CLK_OFF) & ((pre_cnt & pre_mask) == pre_mask);

  // prescaler runs always so a division change needs no restart;
  // the price is that the first tick after a select may come early
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pre_cnt <= '0;
    end else if (ce) begin
      pre_cnt <= pre_cnt + 10'h001;
    end
  end

  // mode dependent stepping of the high half
  wire split_md = (operation_mode_select == MODE_TWO_COUNTER);
  wire upper_md = (operation_mode_select == MODE_UPPER_CLEAR);

  // low half: runs on every timer clock in all modes
  assign lo.tick   = tick;
  assign lo.clear  = rst_lo | hard_lo;
  assign lo.wr     = wr_low_count;
  assign lo.wdata  = rif.wdata;
  assign lo.period = low_period;

  // high half: split counts alone, normal cascades on low bottom
  // split, normal and reserved stepping
  assign hi.tick   = split_md ? tick : (~upper_md & lo.bottom);
  // upper byte forced zero per tick
  assign hi.clear  = rst_hi | hard_hi | (upper_md & tick);
  assign hi.wr     = wr_high_count;
  assign hi.wdata  = rif.wdata;
  assign hi.period = high_period;

  // flag set and clear vectors
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [7:0] next_flags;
  logic [3:0] cmp_match;    // match on this timer clock
  logic [3:0] next_wave;
  logic [11:0] next_irq_level; // request levels for the next edge

  assign flag_set[FLAG_LOW_UNF]  = lo.bottom;
  assign flag_set[FLAG_HIGH_UNF] = hi.bottom;
  assign flag_set[3:2]           = 2'b00;

  // per compare channel: match, flag and waveform
  genvar gi;
  generate
    for (gi = 0; gi < N_CMP; gi++) begin : g_cmp
      // compare flag on low count match
      assign cmp_match[gi] = tick & (lo.count == low_compare_value[gi]);
      assign flag_set[FLAG_CMP_LSB+gi] = cmp_match[gi];
      // waveform set on match, dropped at bottom, restart or hard reset
      // a low half restart zeroes compare outputs
      assign next_wave[gi] = (lo.clear | lo.bottom) ? 1'b0 :
                             cmp_match[gi] ? 1'b1 : wave_out[gi];
      assign next_irq_level[2*(gi+2)+:2] =
          irq_flags[FLAG_CMP_LSB+gi] ? compare_irq_level[2*gi+:2] : 2'b00;
    end
  endgenerate

  // clears: written ones, vector acknowledge, hard reset of a half
  // ack or written one clears
  assign flag_clr = ({8{wr_flags}} & rif.wdata)
                  | {irq_ack[5:2], 2'b00, irq_ack[1:0]}
                  | {{4{hard_lo}}, 2'b00, hard_hi, hard_lo};
  // a new event wins over a clear in the same cycle
  assign next_flags = ((irq_flags & ~flag_clr) | flag_set) & FLAG_MASK;

  // flag and waveform state
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_flags <= REG_RESET;
      wave_out  <= 4'h0;
    end else if (ce) begin
      irq_flags <= next_flags;
      wave_out  <= next_wave;
    end
  end

  // underflow requests carry their level while the flag is up
  // low underflow request level
  assign next_irq_level[1:0] = irq_flags[FLAG_LOW_UNF] ? low_underflow_irq_level : 2'b00;
  assign next_irq_level[3:2] = irq_flags[FLAG_HIGH_UNF] ? high_underflow_irq_level : 2'b00;

  // all request levels leave one register, one cycle behind the flags;
  // a level of zero means the source is masked
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_level <= 12'h000;
    end else if (ce) begin
      irq_level <= next_irq_level;
    end
  end

  // shared control: clock select and mode, untouched by half resets
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      clk_select            <= CLK_OFF;
      operation_mode_select <= MODE_NORMAL;
    end else if (ce) begin
      if (wr_clk) clk_select <= rif.wdata[3:0] & CLK_MASK[3:0];
      // reserved mode 11 is stored and runs as normal
      if (wr_mode) operation_mode_select <= sdt_mode_t'(rif.wdata[1:0] & MODE_MASK[1:0]);
    end
  end

  // low half registers; compare levels go with the low half since
  // only the low half raises compare requests
  // hard reset restores low half
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      low_period              <= REG_RESET;
      low_underflow_irq_level <= 2'b00;
      compare_irq_level       <= REG_RESET;
    end else if (ce) begin
      // hard reset outranks any write
      if (hard_lo) begin
        low_period              <= REG_RESET;
        low_underflow_irq_level <= 2'b00;
        compare_irq_level       <= REG_RESET;
      end else begin
        if (wr_low_half_period) low_period <= rif.wdata;
        if (wr_unf) low_underflow_irq_level <= rif.wdata[1:0];
        if (wr_cmpl) compare_irq_level <= rif.wdata;
      end
    end
  end

  // compare values, cleared with the low half
  // hard reset clears compare values
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < N_CMP; i++) begin
        low_compare_value[i] <= REG_RESET;
      end
    end else if (ce) begin
      if (hard_lo) begin
        for (int i = 0; i < N_CMP; i++) begin
          low_compare_value[i] <= REG_RESET;
        end
      end else if (rif.wr & cmp_hit) begin
        // one slot per write, chosen by the index
        low_compare_value[cmp_sel] <= rif.wdata;
      end
    end
  end

  // high half registers; clock select and mode are left alone
  // hard reset restores high half
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      high_period              <= REG_RESET;
      high_underflow_irq_level <= 2'b00;
    end else if (ce) begin
      // hard reset outranks any write
      if (hard_hi) begin
        high_period              <= REG_RESET;
        high_underflow_irq_level <= 2'b00;
      end else begin
        if (wr_high_period) high_period <= rif.wdata;
        if (wr_unf) high_underflow_irq_level <= rif.wdata[3:2];
      end
    end
  end
endmodule : sdt_timer
`default_nettype wire

/* File: bench/sdt_timer_sva.sv */
// concurrent checks on the timer's apb port and its interrupt and wave outputs
// assumes one clock domain, clk_sys, and reset_n active low
`timescale 1ns/100ps
`default_nettype none
module sdt_timer_sva
  import sdt_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  event_in,
  input wire logic [5:0]  irq_ack,
  input wire logic [11:0] irq_level,
  input wire logic [3:0]  wave_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // read setup cycle: read data is captured at its edge
  logic rd_setup;
  assign rd_setup = psel && !penable && !pwrite && ce;
  a_ready_access: assert property (pready |-> psel && penable && ce)
    else $error("ready outside an access cycle");
  a_zero_wait: assert property (psel && !penable && ce ##1 psel && penable && ce |-> pready)
    else $error("access cycle not answered at once");
  a_err_refused: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("unaligned access not refused");
  a_err_rdata_zero: assert property (rd_setup && paddr[1:0] != 2'b00 |=> prdata == 32'h0000_0000)
    else $error("refused read returned data");
  a_rdata_holds: assert property (!(psel && !penable && ce) |=> $stable(prdata))
    else $error("read data moved without a capture");
  a_cmd_reads_zero: assert property (rd_setup && paddr[7:2] == IDX_CMD |=> prdata == 0)
    else $error("command register read nonzero");
  a_mode_rsvd_zero: assert property (rd_setup && paddr[7:2] == IDX_BYTE_MODE |=> prdata[31:2] == 0)
    else $error("mode reserved bits nonzero");
  a_unf_rsvd_zero: assert property (rd_setup && paddr[7:2] == IDX_UNF_LVL |=> prdata[31:4] == 0)
    else $error("level reserved bits nonzero");
  a_flag_rsvd_zero: assert property (rd_setup && paddr[7:2] == IDX_FLAGS |=> prdata[3:2] == 0)
    else $error("flag reserved bits nonzero");
  a_release_quiet: assert property ($rose(reset_n) |-> irq_level == 0 && wave_out == 0)
    else $error("outputs not idle at reset release");
endmodule : sdt_timer_sva

bind sdt_timer sdt_timer_sva sdt_timer_sva_inst (.clk_sys(clk_sys), .reset_n(reset_n),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_in(event_in),
  .irq_ack(irq_ack), .irq_level(irq_level), .wave_out(wave_out));
`default_nettype wire

/* File: bench/sdt_timer_tb.sv */
// self-checking bench for the split dual byte timer
// assumes sdt_pkg compiled first; events on channel 0 clock the counters
`timescale 1ns/100ps
`default_nettype none
module sdt_timer_tb
  import sdt_pkg::*;
;
  logic        clk_sys    = 1'b0;           // 25 MHz clock
  logic        reset_n    = 1'b0;           // active-low reset
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0000_0000;
  logic [7:0]  event_in   = 8'h00;          // bit 0 is the counting event
  logic [5:0]  irq_ack    = 6'h00;          // vector-executed pulses
  logic        ce         = 1'b1;           // clock enable
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] irq_level;
  logic [3:0]  wave_out;
  int          errors     = 0;
  int          n_compared = 0;
  int          cycles     = 0;
  int          seed       = 89261;

  always #20 clk_sys = ~clk_sys;

  // clock enable is dropped once to see that counting freezes
  sdt_timer sdt_timer_inst (.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_in(event_in), .irq_ack(irq_ack),
    .irq_level(irq_level), .wave_out(wave_out));

  task automatic complete_run;
    $display("mismatches %0d, compares %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  // hang guard: the run needs well under this many cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      complete_run();
    end
  end

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; ev raises the counting event during the access cycle
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] wd,
                     input logic ev, output logic [7:0] rd, output logic err);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= {24'h00_0000, wd};
    @(posedge clk_sys);
    penable  <= 1'b1;
    event_in <= {7'h00, ev};
    // hold the access until pready is seen high at an edge; take the answer there
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd  = prdata[7:0];
    err = pslverr;
    psel     <= 1'b0;
    penable  <= 1'b0;
    event_in <= 8'h00;
  endtask : apb

  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    logic       e;
    apb(1'b1, {idx, 2'b00}, wd, 1'b0, d, e);
  endtask : wr

  // read a register and compare under a mask
  task automatic rdc(input logic [5:0] idx, input logic [7:0] exp, input logic [7:0] msk);
    logic [7:0] d;
    logic       e;
    apb(1'b0, {idx, 2'b00}, 8'h00, 1'b0, d, e);
    check({4'h0, d & msk}, {4'h0, exp & msk});
  endtask : rdc

  // one counting event, exactly one cycle long
  task automatic tick;
    @(posedge clk_sys);
    event_in <= 8'h01;
    @(posedge clk_sys);
    event_in <= 8'h00;
  endtask : tick

  // expected request levels: source i at [2i+1:2i] when its flag is set
  function automatic logic [11:0] exp_irq(input logic [7:0] f, input logic [7:0] ul,
                                           input logic [7:0] cl);
    logic [11:0] r;
    r = 12'h000;
    if (f[0]) r[1:0] = ul[1:0];
    if (f[1]) r[3:2] = ul[3:2];
    for (int i = 0; i < 4; i++) if (f[4+i]) r[4+2*i+:2] = cl[2*i+:2];
    return r;
  endfunction : exp_irq

  initial begin
    logic [7:0] lc, hc, lp, hp, cv, fl, ul, cl, msk, d;
    logic [7:0] cmp [4];
    logic       e;
    logic       hstep;
    logic [5:0] regs [8] = '{IDX_BYTE_MODE, IDX_UNF_LVL, IDX_CMP_LVL, IDX_CMD, IDX_FLAGS,
                             IDX_LOW_COUNT, IDX_HIGH_COUNT, IDX_LOW_PERIOD};
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    foreach (regs[i]) rdc(regs[i], 8'h00, 8'hFF);
    wr(IDX_BYTE_MODE, 8'h03);
    rdc(IDX_BYTE_MODE, 8'h03, 8'hFF);
    wr(IDX_UNF_LVL, 8'h0F);
    rdc(IDX_UNF_LVL, 8'h0F, 8'hFF);
    wr(IDX_CMD, 8'h0B);
    rdc(IDX_CMD, 8'h00, 8'hFF);
    // unmapped index and unaligned address are both refused with zero data
    apb(1'b0, 8'hFC, 8'h00, 1'b0, d, e);
    check({3'h0, e, d}, 12'h100);
    apb(1'b0, 8'h81, 8'h00, 1'b0, d, e);
    check({3'h0, e, d}, 12'h100);
    // counting in normal, upper-clear and two-counter modes against a model
    for (int m = 0; m < 3; m++) begin
      ul  = 8'($random(seed)) & 8'h0F;
      cl  = 8'($random(seed));
      lc  = {5'h00, 3'($random(seed))};
      lp  = {5'h00, 3'($random(seed))} + 8'h03;
      hc  = {6'h00, 2'($random(seed))};
      hp  = 8'($random(seed));
      cv  = {5'h00, 3'($random(seed))};
      cmp = '{cv, 8'h00, 8'h00, 8'h00};
      wr(IDX_CLK_SELECT, 8'h00);
      wr(IDX_BYTE_MODE, {6'h00, m[1:0]});
      wr(IDX_UNF_LVL, ul);
      wr(IDX_CMP_LVL, cl);
      wr(IDX_LOW_COUNT, lc);
      wr(IDX_HIGH_COUNT, hc);
      wr(IDX_LOW_PERIOD, lp);
      wr(IDX_HIGH_PERIOD, hp);
      wr(IDX_CMP_BASE, cv);
      wr(IDX_FLAGS, 8'hF3);
      fl = 8'h00;
      wr(IDX_CLK_SELECT, 8'h08);
      repeat (20) begin
        tick();
        for (int i = 0; i < 4; i++) if (lc == cmp[i]) fl[4+i] = 1'b1;
        hstep = (lc == 8'h00);
        if (hstep) begin
          fl[0] = 1'b1;
          lc    = lp;
        end else lc = lc - 8'h01;
        if (m == 1) hc = 8'h00;
        else if (m == 2 || hstep) begin
          if (hc == 8'h00) begin
            fl[1] = 1'b1;
            hc    = hp;
          end else hc = hc - 8'h01;
        end
      end
      // the high underflow flag is left open in upper-clear mode
      msk = (m == 1) ? 8'hF1 : 8'hF3;
      rdc(IDX_LOW_COUNT, lc, 8'hFF);
      rdc(IDX_HIGH_COUNT, hc, 8'hFF);
      rdc(IDX_FLAGS, fl, msk);
      if (m != 1) check(irq_level, exp_irq(fl, ul, cl));
      @(posedge clk_sys);
      irq_ack <= 6'h03;
      @(posedge clk_sys);
      irq_ack <= 6'h00;
      fl = fl & 8'hFC;
      rdc(IDX_FLAGS, fl, msk);
      check(irq_level, exp_irq(fl, ul, cl));
      wr(IDX_FLAGS, 8'h10);
      fl = fl & 8'hEC;
      rdc(IDX_FLAGS, fl, msk);
      lc = 8'($random(seed));
      apb(1'b1, {IDX_LOW_COUNT, 2'b00}, lc, 1'b1, d, e);
      rdc(IDX_LOW_COUNT, lc, 8'hFF);
    end
    // every command and target while running: only restarts act
    wr(IDX_BYTE_MODE, 8'h02);
    // a low clock enable holds the count through a timer clock
    wr(IDX_LOW_COUNT, 8'h20);
    @(posedge clk_sys);
    ce <= 1'b0;
    tick();
    ce <= 1'b1;
    rdc(IDX_LOW_COUNT, 8'h20, 8'hFF);
    tick();
    rdc(IDX_LOW_COUNT, 8'h1F, 8'hFF);
    for (int c = 0; c < 16; c++) begin
      wr(IDX_LOW_COUNT, 8'h55);
      wr(IDX_HIGH_COUNT, 8'h66);
      wr(IDX_CMD, 8'(c));
      rdc(IDX_LOW_COUNT, (c[3:2] == 2'b10 && c[0]) ? 8'h00 : 8'h55, 8'hFF);
      rdc(IDX_HIGH_COUNT, (c[3:2] == 2'b10 && c[1]) ? 8'h00 : 8'h66, 8'hFF);
    end
    check({8'h00, wave_out}, 12'h000);
    // hard reset with the clock off, one half at a time
    wr(IDX_CLK_SELECT, 8'h00);
    wr(IDX_UNF_LVL, 8'h0F);
    wr(IDX_CMP_LVL, 8'hFF);
    wr(IDX_LOW_PERIOD, 8'h44);
    wr(IDX_HIGH_PERIOD, 8'h77);
    wr(IDX_CMD, 8'h0D);
    rdc(IDX_LOW_COUNT, 8'h00, 8'hFF);
    rdc(IDX_LOW_PERIOD, 8'h00, 8'hFF);
    rdc(IDX_CMP_LVL, 8'h00, 8'hFF);
    rdc(IDX_HIGH_COUNT, 8'h66, 8'hFF);
    rdc(IDX_HIGH_PERIOD, 8'h77, 8'hFF);
    rdc(IDX_UNF_LVL, 8'h0C, 8'hFF);
    wr(IDX_CMD, 8'h0E);
    rdc(IDX_HIGH_COUNT, 8'h00, 8'hFF);
    rdc(IDX_HIGH_PERIOD, 8'h00, 8'hFF);
    rdc(IDX_UNF_LVL, 8'h00, 8'hFF);
    complete_run();
  end
endmodule : sdt_timer_tb
`default_nettype wire
